//--- bus_host_model.sv
// Two-wire bus host: makes START and STOP, moves bytes out and in.
// Assumes pull-ups outside; o_sda_low pulls the data wire.
`timescale 1ns/10ps
module bus_host_model (
    input wire i_sda,
    output reg o_scl,
    output reg o_sda_low,
    output reg o_rx_stb,
    output reg [7:0] o_rx_byte
);
    initial begin
        o_scl = 1'b1;
        o_sda_low = 1'b0;
        o_rx_stb = 1'b0;
        o_rx_byte = 8'h00;
    end
    // Data set in the low phase, sampled late in the high phase
    task bit_io(input b, output r);
        #20 o_sda_low = !b;
        #42.5 o_scl = 1'b1;
        #62 r = i_sda;
        #0.5 o_scl = 1'b0;
    endtask
    task start_c;
        #62.5 o_sda_low = 1'b1;
        #62.5 o_scl = 1'b0;
    endtask
    task stop_c;
        #20 o_sda_low = 1'b1;
        #42.5 o_scl = 1'b1;
        #62.5 o_sda_low = 1'b0;
        #125;
    endtask
    task send(input [7:0] d, output ack);
        reg r;
        integer i;
        for (i = 7; i >= 0; i = i - 1) bit_io(d[i], r);
        bit_io(1'b1, r);
        ack = !r;
    endtask
    // Host acknowledge keeps the read going; the last byte is refused
    task recv(input last, output [7:0] d);
        reg r;
        integer i;
        for (i = 7; i >= 0; i = i - 1) bit_io(1'b1, d[i]);
        bit_io(last, r);
        o_rx_byte = d;
        o_rx_stb = !o_rx_stb;
    endtask
endmodule // bus_host_model

//--- rtc_core_assertions.sv
// Checker for the seconds counter core pins.
// Assumes binding onto seconds_counter_rtc_core.
`timescale 1ns/10ps
module rtc_core_checker #(
    parameter [31:0] RELEASE_CYCLES = 200,
    parameter [31:0] STARTUP_CYCLES = 100
) (
    input wire i_clk_sys,
    input wire i_rst,
    input wire i_power_ok,
    input wire i_scl,
    input wire o_sda,
    input wire o_sda_oe,
    input wire o_rst_n,
    input wire o_rst_n_oe
);
    // Cycles since the supply last came good
    reg [31:0] ok_cnt_ff;
    always @(posedge i_clk_sys) begin
        if (i_rst || !i_power_ok)
            ok_cnt_ff <= 32'h0;
        else
            ok_cnt_ff <= ok_cnt_ff + 32'h1;
    end
    ////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);
    sequence pf_low_s;
        !i_power_ok [*6];
    endsequence
    sequence hold_done_s;
        $fell(o_rst_n_oe);
    endsequence
    sda_low_only_a: assert property (o_sda_oe |-> !o_sda)
        else $error("data pin driven high");
    rst_low_only_a: assert property (o_rst_n_oe |-> !o_rst_n)
        else $error("reset pin driven high");
    rst_in_reset_a: assert property (disable iff (1'b0) i_rst |=> o_rst_n_oe)
        else $error("reset pin idle in reset");
    pfail_reset_a: assert property (pf_low_s |-> o_rst_n_oe)
        else $error("reset not active on supply loss");
    pfail_quiet_a: assert property (pf_low_s |-> ##2 !o_sda_oe)
        else $error("bus driven on supply loss");
    hold_min_a: assert property (hold_done_s |-> ok_cnt_ff >= RELEASE_CYCLES)
        else $error("reset released early");
    hold_max_a: assert property
        (ok_cnt_ff == RELEASE_CYCLES + STARTUP_CYCLES + 32'd12 |-> !o_rst_n_oe)
        else $error("reset held too long");
    sda_scl_low_a: assert property ($changed(o_sda_oe) |-> !$past(i_scl, 2))
        else $error("data changed while clock high");
    reset_quiet_a: assert property
        (o_rst_n_oe && $past(o_rst_n_oe, 2) |-> !o_sda_oe)
        else $error("bus answered during reset");
endmodule // rtc_core_checker
bind seconds_counter_rtc_core rtc_core_checker #(
    .RELEASE_CYCLES(RELEASE_CYCLES), .STARTUP_CYCLES(STARTUP_CYCLES)
) chk_u (
    .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_power_ok(i_power_ok),
    .i_scl(i_scl), .o_sda(o_sda), .o_sda_oe(o_sda_oe),
    .o_rst_n(o_rst_n), .o_rst_n_oe(o_rst_n_oe)
);

//--- seconds_counter_rtc_core.v
// Seconds counter RTC core: oscillator edge counting, two-wire target,
// supply monitor driven reset output.
// Assumes i_power_ok is a comparator level and pins are open drain outside.
`timescale 1ns/10ps
`include "seconds_counter_rtc_map.vh"
module seconds_counter_rtc_core #(
    parameter [6:0] DEV_ADDR = `DEV_ADDR_DEFAULT,
    parameter OSC_HZ = `OSC_HZ,
    parameter [31:0] RELEASE_CYCLES =
        `RESET_RELEASE_DELAY_MS * (`SYS_HZ / 1000),
    parameter [31:0] STARTUP_CYCLES = `OSC_STARTUP_MS * (`SYS_HZ / 1000),
    parameter [15:0] STARTUP_TICKS = OSC_HZ * `OSC_STARTUP_MS / 1000
) (
    input wire i_clk_sys,
    input wire i_rst,
    input wire i_xtal_in,
    input wire i_power_ok,
    input wire i_scl,
    input wire i_sda,
    output reg o_sda,
    output reg o_sda_oe,
    output reg o_rst_n,
    output reg o_rst_n_oe
);
    ////////////////////////////////////////////////////////////////////////
    wire xtal_s;
    wire scl_s;
    wire sda_s;
    wire pwr_s;
    sync3 u_sx (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
        .i_async(i_xtal_in), .o_level(xtal_s));
    sync3 u_sc (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
        .i_async(i_scl), .o_level(scl_s));
    sync3 u_sd (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
        .i_async(i_sda), .o_level(sda_s));
    sync3 u_sp (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
        .i_async(i_power_ok), .o_level(pwr_s));
    reg xtal_d_ff;
    reg scl_d_ff;
    reg sda_d_ff;
    wire xtal_rise = xtal_s & ~xtal_d_ff;
    wire scl_rise = scl_s & ~scl_d_ff;
    wire scl_fall = ~scl_s & scl_d_ff;
    wire start_c = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
    wire stop_c = scl_s & scl_d_ff & ~sda_d_ff & sda_s;
    ////////////////////////////////////////////////////////////////////////
    // Oscillator divider and seconds counter
    reg [15:0] div_ff;
    reg [15:0] startup_ff;
    reg [31:0] count_ff;
    reg [7:0] ctrl_ff;
    reg [7:0] trickle_ff;
    reg osc_ready_ff;
    reg sec_tick_ff;
    wire osc_stop = ctrl_ff[`CTRL_OSC_STOP_BIT];
    reg wr_en;
    reg [2:0] wr_addr;
    reg [7:0] wr_data;
    always @(posedge i_clk_sys) begin
        if (i_rst) begin
            div_ff <= 16'h0000;
            startup_ff <= 16'h0000;
            osc_ready_ff <= 1'b0;
            sec_tick_ff <= 1'b0;
        end else begin
            sec_tick_ff <= 1'b0;
            if (xtal_rise) begin
                if (!osc_ready_ff) begin
                    startup_ff <= startup_ff + 16'h0001;
                    if (startup_ff == STARTUP_TICKS - 16'h0001) begin
                        osc_ready_ff <= 1'b1;
                    end
                end else if (div_ff == OSC_HZ - 1) begin
                    div_ff <= 16'h0000;
                    sec_tick_ff <= 1'b1;
                end else begin
                    div_ff <= div_ff + 16'h0001;
                end
            end
        end
    end
    // Counter runs on independent of power state
    always @(posedge i_clk_sys) begin
        if (i_rst) begin
            count_ff <= 32'h00000000;
            ctrl_ff <= `CTRL_RESET;
            trickle_ff <= `TRICKLE_RESET;
        end else begin
            if (sec_tick_ff && !osc_stop) begin
                count_ff <= count_ff + 32'h00000001;
            end
            if (wr_en) begin
                case (wr_addr)
                    `REG_CNT0: count_ff[7:0] <= wr_data;
                    `REG_CNT1: count_ff[15:8] <= wr_data;
                    `REG_CNT2: count_ff[23:16] <= wr_data;
                    `REG_CNT3: count_ff[31:24] <= wr_data;
                    `REG_CTRL: ctrl_ff <= wr_data;
                    `REG_TRICKLE: trickle_ff <= wr_data;
                    default: ;
                endcase
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // Power monitor and reset output
    reg [31:0] hold_ff;
    reg pf_ff;
    always @(posedge i_clk_sys) begin
        if (i_rst) begin
            hold_ff <= RELEASE_CYCLES;
            pf_ff <= 1'b1;
            o_rst_n <= 1'b0;
            o_rst_n_oe <= 1'b1;
        end else begin
            o_rst_n <= 1'b0;
            if (!pwr_s) begin
                pf_ff <= 1'b1;
                hold_ff <= osc_stop ? RELEASE_CYCLES + STARTUP_CYCLES
                                    : RELEASE_CYCLES;
            end else if (hold_ff != 32'h00000000) begin
                hold_ff <= hold_ff - 32'h00000001;
            end else begin
                pf_ff <= 1'b0;
            end
            o_rst_n_oe <= !pwr_s || hold_ff != 32'h00000000 || pf_ff;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // Two-wire target
    localparam ST_IDLE = 3'h0;
    localparam ST_DEVA = 3'h1;
    localparam ST_REGA = 3'h2;
    localparam ST_WDAT = 3'h3;
    localparam ST_RDAT = 3'h4;
    localparam ST_ACK = 3'h5;
    localparam ST_RACK = 3'h6;
    reg [2:0] st_ff;
    reg [2:0] ret_ff;
    reg [3:0] bit_ff;
    reg [7:0] sh_ff;
    reg [2:0] ptr_ff;
    reg [31:0] snap_ff;
    reg rd_ff;
    function [2:0] next_ptr;
        input [2:0] p;
        begin
            next_ptr = (p == `REG_LAST) ? `REG_CNT0 : p + 3'h1;
        end
    endfunction
    function [7:0] rd_byte;
        input [2:0] p;
        input [31:0] s;
        begin
            case (p)
                `REG_CNT0: rd_byte = s[7:0];
                `REG_CNT1: rd_byte = s[15:8];
                `REG_CNT2: rd_byte = s[23:16];
                `REG_CNT3: rd_byte = s[31:24];
                `REG_CTRL: rd_byte = ctrl_ff;
                `REG_TRICKLE: rd_byte = trickle_ff;
                default: rd_byte = 8'h00;
            endcase
        end
    endfunction
    wire [7:0] rd_cur = rd_byte(ptr_ff, snap_ff);
    always @* begin
        wr_en = 1'b0;
        wr_addr = ptr_ff;
        wr_data = {sh_ff[6:0], sda_s};
        if (st_ff == ST_WDAT && scl_rise && bit_ff == 4'h7 && !pf_ff) begin
            wr_en = 1'b1;
        end
    end
    always @(posedge i_clk_sys) begin
        if (i_rst) begin
            xtal_d_ff <= 1'b1;
            scl_d_ff <= 1'b1;
            sda_d_ff <= 1'b1;
            st_ff <= ST_IDLE;
            ret_ff <= ST_IDLE;
            bit_ff <= 4'h0;
            sh_ff <= 8'h00;
            ptr_ff <= `REG_CNT0;
            snap_ff <= 32'h00000000;
            rd_ff <= 1'b0;
            o_sda <= 1'b0;
            o_sda_oe <= 1'b0;
        end else begin
            xtal_d_ff <= xtal_s;
            scl_d_ff <= scl_s;
            sda_d_ff <= sda_s;
            o_sda <= 1'b0;
            if (pf_ff || stop_c) begin
                st_ff <= ST_IDLE;
                o_sda_oe <= 1'b0;
            end else if (start_c) begin
                st_ff <= ST_DEVA;
                bit_ff <= 4'h0;
                o_sda_oe <= 1'b0;
                snap_ff <= count_ff;
            end else begin
                case (st_ff)
                    ST_DEVA, ST_REGA, ST_WDAT: begin
                        if (scl_rise) begin
                            sh_ff <= {sh_ff[6:0], sda_s};
                            bit_ff <= bit_ff + 4'h1;
                        end
                        if (scl_fall && bit_ff == 4'h8) begin
                            bit_ff <= 4'h0;
                            if (st_ff == ST_DEVA) begin
                                if (sh_ff[7:1] == DEV_ADDR) begin
                                    o_sda_oe <= 1'b1;
                                    rd_ff <= sh_ff[0];
                                    ret_ff <= sh_ff[0] ? ST_RDAT : ST_REGA;
                                    st_ff <= ST_ACK;
                                end else begin
                                    st_ff <= ST_IDLE;
                                end
                            end else begin
                                if (st_ff == ST_REGA) begin
                                    ptr_ff <= sh_ff[2:0];
                                end else begin
                                    ptr_ff <= next_ptr(ptr_ff);
                                end
                                o_sda_oe <= 1'b1;
                                ret_ff <= ST_WDAT;
                                st_ff <= ST_ACK;
                            end
                        end
                    end
                    ST_ACK: begin
                        if (scl_fall) begin
                            if (ret_ff == ST_RDAT) begin
                                sh_ff <= rd_cur;
                                o_sda_oe <= ~rd_cur[7];
                            end else begin
                                o_sda_oe <= 1'b0;
                            end
                            st_ff <= ret_ff;
                        end
                    end
                    ST_RDAT: begin
                        if (scl_fall) begin
                            bit_ff <= bit_ff + 4'h1;
                            if (bit_ff == 4'h7) begin
                                o_sda_oe <= 1'b0;
                                bit_ff <= 4'h0;
                                ptr_ff <= next_ptr(ptr_ff);
                                st_ff <= ST_RACK;
                            end else begin
                                sh_ff <= {sh_ff[6:0], 1'b0};
                                o_sda_oe <= ~sh_ff[6];
                            end
                        end
                    end
                    ST_RACK: begin
                        if (scl_rise) begin
                            st_ff <= sda_s ? ST_IDLE : ST_ACK;
                            ret_ff <= ST_RDAT;
                        end
                    end
                    default: begin
                        o_sda_oe <= 1'b0;
                    end
                endcase
            end
        end
    end
endmodule // seconds_counter_rtc_core

//--- seconds_counter_rtc_map.vh
// Constants for the seconds counter RTC core: register map, timing counts.
// Assumes inclusion by the design modules only.
`ifndef SECONDS_COUNTER_RTC_MAP_VH
`define SECONDS_COUNTER_RTC_MAP_VH
`define REG_CNT0 3'h0
`define REG_CNT1 3'h1
`define REG_CNT2 3'h2
`define REG_CNT3 3'h3
`define REG_CTRL 3'h4
`define REG_TRICKLE 3'h5
`define REG_LAST 3'h5
`define CTRL_OSC_STOP_BIT 7
`define CTRL_RESET 8'h00
`define TRICKLE_RESET 8'h00
`define OSC_HZ 32768
`define SYS_HZ 100000000
`define RESET_RELEASE_DELAY_MS 250
`define OSC_STARTUP_MS 1000
// Bus address of the target; the value is arbitrary
`define DEV_ADDR_DEFAULT 7'h2c
`endif

//--- sync3.v
// Three-stage input synchroniser with change taken once stages 2 and 3 agree.
// Assumes the input is asynchronous to i_clk_sys.
`timescale 1ns/10ps
module sync3 (
    input wire i_clk_sys,
    input wire i_rst,
    input wire i_async,
    output reg o_level
);
    reg s1_ff;
    reg s2_ff;
    reg s3_ff;
    always @(posedge i_clk_sys) begin
        if (i_rst) begin
            s1_ff <= 1'b1;
            s2_ff <= 1'b1;
            s3_ff <= 1'b1;
            o_level <= 1'b1;
        end else begin
            s1_ff <= i_async;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            if (s2_ff == s3_ff) begin
                o_level <= s3_ff;
            end
        end
    end
endmodule // sync3

//--- tb_top.sv
// Self-checking bench: bus host model, oscillator and supply driven.
// Assumes the core, its checker and the host model compiled first.
`timescale 1ns/10ps
module tb_top;
    localparam [31:0] REL = 200;
    localparam [31:0] STU = 100;
    reg i_clk_sys, i_rst, i_xtal_in, i_power_ok, ak, ok_all, ok;
    wire scl, host_low, o_sda, sda_oe, rst_n, rst_oe, rx_stb;
    wire [7:0] rx_byte;
    wire sda = !(host_low || (sda_oe && !o_sda));
    integer num_errors = 0, check_count = 0, seed = 83;
    reg [8:0] exp_q [$];
    reg [8:0] e9;
    reg [7:0] wd [0:7];
    reg [31:0] last32;
    seconds_counter_rtc_core #(.OSC_HZ(8), .RELEASE_CYCLES(REL),
        .STARTUP_CYCLES(STU), .STARTUP_TICKS(16'h4)) dut_u (
        .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_xtal_in(i_xtal_in),
        .i_power_ok(i_power_ok), .i_scl(scl), .i_sda(sda), .o_sda(o_sda),
        .o_sda_oe(sda_oe), .o_rst_n(rst_n), .o_rst_n_oe(rst_oe));
    bus_host_model host_u (.i_sda(sda), .o_scl(scl), .o_sda_low(host_low),
        .o_rx_stb(rx_stb), .o_rx_byte(rx_byte));
    ////////////////////////////////////////////////////////////////////
    task check_val(input [31:0] e, input [31:0] g);
        check_count = check_count + 1;
        if (g !== e) begin
            num_errors = num_errors + 1;
            $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    task check_byte(input [7:0] e, input [7:0] g);
        check_val({24'h0, e}, {24'h0, g});
    endtask
    task finish_test;
        $display("errors=%0d checks=%0d", num_errors, check_count);
        if (num_errors == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task wr_regs(input [7:0] dev, input [7:0] ra, input integer n);
        integer i;
        host_u.start_c;
        host_u.send(dev, ok_all);
        host_u.send(ra, ak);
        ok_all = ok_all & ak;
        for (i = 0; i < n; i = i + 1) begin
            host_u.send(wd[i], ak);
            ok_all = ok_all & ak;
        end
        host_u.stop_c;
    endtask
    task rd_regs(input [7:0] ra, input integer n);
        integer i;
        reg [7:0] d;
        wr_regs(8'h58, ra, 0);
        host_u.start_c;
        host_u.send(8'h59, ak);
        for (i = 0; i < n; i = i + 1) host_u.recv(i == n - 1, d);
        host_u.stop_c;
    endtask
    task hold_len(output integer t);
        t = 0;
        while (rst_oe === 1'b1 && t < 900) begin
            @(negedge i_clk_sys);
            t = t + 1;
        end
    endtask
    // Read bytes are matched against the oldest note
    always @(rx_stb) begin
        last32 = {rx_byte, last32[31:8]};
        if (exp_q.size() > 0) begin
            e9 = exp_q.pop_front();
            if (!e9[8])
                check_byte(e9[7:0], rx_byte);
        end
    end
    ////////////////////////////////////////////////////////////////////
    initial begin
        i_clk_sys = 1'b0;
        forever #5 i_clk_sys = !i_clk_sys;
    end
    initial begin
        i_xtal_in = 1'b0;
        forever #500 i_xtal_in = !i_xtal_in;
    end
    initial begin
        #400000;
        num_errors = num_errors + 1;
        finish_test;
    end
    initial begin : main
        integer i;
        integer t;
        reg [31:0] cv;
        i_rst = 1'b1;
        i_power_ok = 1'b1;
        repeat (6) @(negedge i_clk_sys);
        i_rst = 1'b0;
        hold_len(t);
        check_val(32'h1, {31'h0, t >= REL && t <= REL + 12});
        // Freeze the count, then write past the last register
        wd[0] = 8'h80;
        wr_regs(8'h58, 8'h04, 1);
        cv = $random(seed);
        for (i = 0; i < 4; i = i + 1) wd[i] = cv[8*i +: 8];
        cv = $random(seed);
        wd[4] = 8'h80;
        wd[5] = cv[15:8];
        wd[6] = ~wd[0];
        wr_regs(8'h58, 8'h00, 7);
        check_val(32'h1, {31'h0, ok_all});
        #10000;
        for (i = 0; i < 7; i = i + 1) begin
            e9 = {1'b0, wd[(i % 6 == 0) ? 6 : i % 6]};
            exp_q.push_back(e9);
        end
        rd_regs(8'h00, 7);
        // Count from all ones with the oscillator enabled
        for (i = 0; i < 4; i = i + 1) wd[i] = 8'hff;
        wd[4] = 8'h00;
        wr_regs(8'h58, 8'h00, 5);
        #12000;
        for (i = 0; i < 4; i = i + 1) exp_q.push_back(9'h100);
        rd_regs(8'h00, 4);
        check_val(32'h1, {31'h0, last32 < 32'h3});
        wd[0] = 8'h80;
        wr_regs(8'h58, 8'h04, 1);
        @(negedge i_clk_sys);
        i_power_ok = 1'b0;
        repeat (10) @(negedge i_clk_sys);
        check_val(32'h1, {31'h0, rst_oe});
        wd[0] = 8'h00;
        wr_regs(8'h58, 8'h04, 1);
        check_val(32'h0, {31'h0, ok_all});
        @(negedge i_clk_sys);
        i_power_ok = 1'b1;
        hold_len(t);
        ok = t >= REL + STU && t <= REL + STU + 12;
        check_val(32'h1, {31'h0, ok});
        wr_regs(8'ha0, 8'h04, 0);
        check_val(32'h0, {31'h0, ok_all});
        exp_q.push_back(9'h080);
        rd_regs(8'h04, 1);
        check_val(32'h0, exp_q.size());
        finish_test;
    end
endmodule // tb_top
